// ===== pkg/serial_port_defines.svh
// register offsets, field positions, reset values and timing counts for the serial port
`ifndef SERIAL_PORT_DEFINES_SVH
`define SERIAL_PORT_DEFINES_SVH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define OFS_CONTROL   12'h000
`define OFS_BUFFER    12'h004
`define OFS_POWER     12'h008
`define OFS_RELOAD    12'h00C
`define OFS_IRQ_STAT  12'h010
`define OFS_IRQ_MASK  12'h014

// ------------------------------------------------------------
// serial control and power register fields
// ------------------------------------------------------------
`define CTL_RX_FLAG   0
`define CTL_TX_FLAG   1
`define CTL_RX_NINTH  2
`define CTL_TX_NINTH  3
`define CTL_RX_EN     4
`define CTL_MP_FILTER 5
`define CTL_MODE_LO   6
`define CTL_MODE_HI   7
`define PWR_DOUBLER   7

// ------------------------------------------------------------
// timing counts in clocks, slices and bits, and reset values
// ------------------------------------------------------------
`define DIV_MODE0     6'd12
`define DIV_MODE0_HALF 6'd6
`define DIV_M2_SLICE  6'd4
`define DIV_M2_SLICE_X2 6'd2
`define DIV_MODE2     6'd32
`define DIV_T1_PRE    4'd12
`define RELOAD_WRAP   9'd256
`define SLICES        4'd15
`define SLICE_S1      4'd8
`define SLICE_S2      4'd9
`define SLICE_S3      4'd10
`define SLICE_HALF    4'd8
`define BITS_MODE0    4'd8
`define BITS_MODE1    4'd10
`define BITS_MODE2    4'd11
`define RESET_CTL     8'h00
`define RESET_RELOAD  8'h00

`endif

// ===== pkg/serial_port_pkg.sv
// types shared by the serial port files
package serial_port_pkg;

	typedef enum logic [1:0] {
		mode_shift = 2'b00,
		mode_uart8 = 2'b01,
		mode_fix9  = 2'b10,
		mode_var9  = 2'b11
	} serial_mode_t;

	// gray coded along idle, start, data, stop
	typedef enum logic [1:0] {
		rx_idle  = 2'b00,
		rx_start = 2'b01,
		rx_data  = 2'b11,
		rx_stop  = 2'b10
	} rx_state_t;

endpackage

// ===== rtl/baud_gen.sv
// baud tick generator: oscillator fractions and timer reload source
`timescale 1ns/10ps
`include "serial_port_defines.svh"

module baud_gen (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       sys_rst,
	input  wire logic       clk_en,
	// configuration
	input  wire logic [1:0] mode,
	input  wire logic       baud_doubler_bit,
	input  wire logic [7:0] timer_reload_high,
	// ticks
	output logic            shift_tick,
	output logic            slice_tick
);

	typedef struct packed {
		logic [5:0] osc_cnt;
		logic [3:0] pre_cnt;
		logic [7:0] tmr;
		logic       t1_half;
		logic       shift_tick;
		logic       slice_tick;
	} bg_state_t;

	bg_state_t st;
	bg_state_t next_st;

	// mode 0 ticks every half bit (bit = 12 clocks), mode 2 slices of 4 or 2, others from timer
	always_comb begin
		logic ovf;
		ovf = 1'b0;
		next_st = st;
		next_st.shift_tick = 1'b0;
		next_st.slice_tick = 1'b0;
		next_st.osc_cnt = st.osc_cnt + 6'd1;
		if (mode == 2'b00) begin
			if (st.osc_cnt >= `DIV_MODE0_HALF - 6'd1) begin
				next_st.osc_cnt = 6'd0;
				next_st.shift_tick = 1'b1;
			end
		end else if (mode == 2'b10) begin
			// slice = bit/16, bit = osc/64 or osc/32
			if (st.osc_cnt >= (baud_doubler_bit ? `DIV_M2_SLICE_X2 : `DIV_M2_SLICE) - 6'd1) begin
				next_st.osc_cnt = 6'd0;
				next_st.slice_tick = 1'b1;
			end
		end
		// timer 1 auto-reload: one tick per 12 clocks, reload on wrap
		next_st.pre_cnt = st.pre_cnt + 4'd1;
		if (st.pre_cnt >= `DIV_T1_PRE - 4'd1) begin
			next_st.pre_cnt = 4'd0;
			if (st.tmr == 8'hFF) begin
				next_st.tmr = timer_reload_high;
				ovf = 1'b1;
			end else begin
				next_st.tmr = st.tmr + 8'd1;
			end
		end
		// bit = ovf * 2^(doubler-5): slice = ovf/2 or ovf
		if (ovf && mode[0]) begin
			next_st.t1_half = ~st.t1_half;
			if (baud_doubler_bit || st.t1_half) begin
				next_st.slice_tick = 1'b1;
			end
		end
	end

	// state register
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st <= '0;
		end else if (clk_en) begin
			st <= next_st;
		end
	end

	assign shift_tick = st.shift_tick;
	assign slice_tick = st.slice_tick;

endmodule

// ===== rtl/serial_regs.sv
// apb register file with read-clear interrupt status
`timescale 1ns/10ps
`include "serial_port_defines.svh"

module serial_regs (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic        clk_en,
	// apb
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// strobes
	output logic             wr_ctl,
	output logic             wr_buf,
	output logic             rd_buf,
	output logic      [7:0]  wdata,
	// state from core
	input  wire logic [7:0]  ctl_val,
	input  wire logic [7:0]  rbuf_val,
	input  wire logic [1:0]  events,
	// programmed values
	output logic             baud_doubler_bit,
	output logic      [7:0]  timer_reload_high,
	output logic             irq
);

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
		logic        doubler;
		logic [7:0]  reload;
		logic [1:0]  stat;
		logic [1:0]  mask;
		logic        irq;
	} rg_state_t;

	rg_state_t st;
	rg_state_t next_st;
	logic      acc;

	assign acc = psel && penable && !st.pready;
	assign wr_ctl = acc && pwrite && paddr == `OFS_CONTROL;
	assign wr_buf = acc && pwrite && paddr == `OFS_BUFFER;
	assign rd_buf = acc && !pwrite && paddr == `OFS_BUFFER;
	assign wdata  = pwdata[7:0];

	// decode, one wait state, read-clear status where a new event wins
	always_comb begin
		next_st = st;
		next_st.pready = acc;
		next_st.pslverr = 1'b0;
		next_st.stat = st.stat | events;
		if (acc) begin
			next_st.prdata = 32'h0000_0000;
			case (paddr)
				`OFS_CONTROL:  next_st.prdata[7:0] = ctl_val;
				`OFS_BUFFER:   next_st.prdata[7:0] = rbuf_val;
				`OFS_POWER:    next_st.prdata[`PWR_DOUBLER] = st.doubler;
				`OFS_RELOAD:   next_st.prdata[7:0] = st.reload;
				`OFS_IRQ_STAT: begin
					next_st.prdata[1:0] = st.stat;
					if (!pwrite) begin
						next_st.stat = events;
					end
				end
				`OFS_IRQ_MASK: next_st.prdata[1:0] = st.mask;
				default:       next_st.pslverr = 1'b1;
			endcase
			if (pwrite) begin
				case (paddr)
					`OFS_POWER:    next_st.doubler = pwdata[`PWR_DOUBLER];
					`OFS_RELOAD:   next_st.reload = pwdata[7:0];
					`OFS_IRQ_MASK: next_st.mask = pwdata[1:0];
					default:       next_st.doubler = st.doubler;
				endcase
			end
		end
		next_st.irq = |(next_st.stat & next_st.mask);
	end

	// state register
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st <= '0;
			st.reload <= `RESET_RELOAD;
		end else if (clk_en) begin
			st <= next_st;
		end
	end

	assign prdata = st.prdata;
	assign pready = st.pready;
	assign pslverr = st.pslverr;
	assign baud_doubler_bit = st.doubler;
	assign timer_reload_high = st.reload;
	assign irq = st.irq;

endmodule

// ===== rtl/serial_port.sv
// local serial port: four modes, shared buffer, apb registers
// Operation
// - load only if flag clear and filter passes
// - stop/ninth to flag, data to buffer
// - hunt next start after stop middle
// - mode 3 equals mode 2 but timer rate
// - buffer write starts transmission
// - mode 0 receives when flag clear, enabled
// - other modes receive on start bit
// - mode 0 rate is osc/12
// - mode 2 rate osc/64 or osc/32
// - modes 1,3 rate from timer overflow
// - auto-reload rate osc/(12*(256-reload))
// - mode 2 frame is eleven bits
// - majority vote at slices 8,9,10
// - mode 1 frame is ten bits
// - mode 0 half duplex, shift clock
//
// Our own choices: the APB interface to the registers and the address map.
`timescale 1ns/10ps
`include "serial_port_defines.svh"

module serial_port (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic        clk_en,
	// apb
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// serial pins
	input  wire logic        rxd_in,
	output logic             rxd_out,
	output logic             rxd_oe,
	output logic             txd,
	// interrupt
	output logic             irq
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic [7:0]                serial_control_reg;
		logic [7:0]                serial_buffer;
		serial_port_pkg::rx_state_t rx_st;
		logic [3:0]                rx_slice;
		logic [3:0]                rx_bits;
		logic [8:0]                rx_shift;
		logic [2:0]                votes;
		logic                      rx_prev;
		logic                      tx_busy;
		logic [3:0]                tx_slice;
		logic [3:0]                tx_bits;
		logic [9:0]                tx_shift;
		logic                      txd;
		logic                      rxd_out;
		logic                      rxd_oe;
		logic                      m0_rx;
		logic                      m0_phase;
		logic [1:0]                events;
	} sp_state_t;

	sp_state_t st;
	sp_state_t next_st;

	logic       wr_ctl;
	logic       wr_buf;
	logic       rd_buf;
	logic [7:0] wdata;
	logic       baud_doubler_bit;
	logic [7:0] timer_reload_high;
	logic       shift_tick;
	logic       slice_tick;
	logic [1:0] mode;

	assign mode = st.serial_control_reg[`CTL_MODE_HI:`CTL_MODE_LO];

	// ------------------------------------------------------------
	// submodules
	// ------------------------------------------------------------
	serial_regs u_regs (
		.clk              (clk),
		.sys_rst          (sys_rst),
		.clk_en           (clk_en),
		.psel             (psel),
		.penable          (penable),
		.pwrite           (pwrite),
		.paddr            (paddr),
		.pwdata           (pwdata),
		.prdata           (prdata),
		.pready           (pready),
		.pslverr          (pslverr),
		.wr_ctl           (wr_ctl),
		.wr_buf           (wr_buf),
		.rd_buf           (rd_buf),
		.wdata            (wdata),
		.ctl_val          (st.serial_control_reg),
		.rbuf_val         (st.serial_buffer),
		.events           (st.events),
		.baud_doubler_bit (baud_doubler_bit),
		.timer_reload_high(timer_reload_high),
		.irq              (irq)
	);

	baud_gen u_baud (
		.clk              (clk),
		.sys_rst          (sys_rst),
		.clk_en           (clk_en),
		.mode             (mode),
		.baud_doubler_bit (baud_doubler_bit),
		.timer_reload_high(timer_reload_high),
		.shift_tick       (shift_tick),
		.slice_tick       (slice_tick)
	);

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		logic       rx_flag;
		logic       bitv;
		logic       nine;
		logic [3:0] frame_bits;
		rx_flag = st.serial_control_reg[`CTL_RX_FLAG];
		bitv = 1'b0;
		nine = mode[1];
		frame_bits = nine ? `BITS_MODE2 : `BITS_MODE1;
		next_st = st;
		next_st.events = 2'b00;
		next_st.rx_prev = rxd_in;

		// software writes control; hardware-set flags win below
		if (wr_ctl) begin
			next_st.serial_control_reg = wdata;
		end

		// ---------------- transmitter ----------------
		if (wr_buf) begin
			next_st.tx_busy = 1'b1;
			next_st.tx_slice = 4'd0;
			next_st.tx_bits = 4'd0;
			next_st.m0_rx = 1'b0;
			next_st.m0_phase = 1'b0;
			// stop, ninth or stop, data; the start bit is driven as tx_bits steps from 0 to 1
			next_st.tx_shift = {1'b1,
				nine ? st.serial_control_reg[`CTL_TX_NINTH] : 1'b1, wdata};
			if (mode == 2'b00) begin
				next_st.rxd_oe = 1'b1;
				next_st.tx_shift = {2'b11, wdata};
			end
		end else if (st.tx_busy && mode == 2'b00) begin
			// shift clock low then high, one bit per shift period
			if (shift_tick) begin
				next_st.m0_phase = ~st.m0_phase;
				if (!st.m0_phase) begin
					next_st.txd = 1'b0;
					next_st.rxd_out = st.tx_shift[0];
				end else begin
					next_st.txd = 1'b1;
					next_st.tx_shift = {1'b1, st.tx_shift[9:1]};
					next_st.tx_bits = st.tx_bits + 4'd1;
					if (st.tx_bits == `BITS_MODE0 - 4'd1) begin
						next_st.tx_busy = 1'b0;
						next_st.rxd_oe = 1'b0;
						next_st.serial_control_reg[`CTL_TX_FLAG] = 1'b1;
						next_st.events[1] = 1'b1;
					end
				end
			end
		end else if (st.tx_busy && slice_tick) begin
			next_st.tx_slice = st.tx_slice + 4'd1;
			if (st.tx_slice == `SLICES) begin
				if (st.tx_bits == 4'd0) begin
					next_st.txd = 1'b0;
				end else begin
					next_st.txd = st.tx_shift[0];
					next_st.tx_shift = {1'b1, st.tx_shift[9:1]};
				end
				next_st.tx_bits = st.tx_bits + 4'd1;
				if (st.tx_bits == frame_bits - 4'd1) begin
					next_st.tx_busy = 1'b0;
					next_st.serial_control_reg[`CTL_TX_FLAG] = 1'b1;
					next_st.events[1] = 1'b1;
				end
			end
		end

		// ---------------- mode 0 receiver ----------------
		if (mode == 2'b00 && !st.tx_busy && !st.m0_rx && !rx_flag
			&& st.serial_control_reg[`CTL_RX_EN]) begin
			next_st.m0_rx = 1'b1;
			next_st.rx_bits = 4'd0;
			next_st.m0_phase = 1'b0;
		end else if (st.m0_rx && shift_tick) begin
			next_st.m0_phase = ~st.m0_phase;
			next_st.txd = st.m0_phase;
			if (st.m0_phase) begin
				next_st.rx_shift = {1'b0, rxd_in, st.rx_shift[7:1]};
				next_st.rx_bits = st.rx_bits + 4'd1;
				if (st.rx_bits == `BITS_MODE0 - 4'd1) begin
					next_st.m0_rx = 1'b0;
					next_st.serial_buffer = {rxd_in, st.rx_shift[7:1]};
					next_st.serial_control_reg[`CTL_RX_FLAG] = 1'b1;
					next_st.events[0] = 1'b1;
				end
			end
		end

		// ---------------- async receiver ----------------
		if (mode != 2'b00) begin
			if (st.rx_st == serial_port_pkg::rx_idle) begin
				if (st.serial_control_reg[`CTL_RX_EN] && st.rx_prev && !rxd_in) begin
					next_st.rx_st = serial_port_pkg::rx_start;
					next_st.rx_slice = 4'd0;
					next_st.rx_bits = 4'd0;
				end
			end else if (slice_tick) begin
				next_st.rx_slice = st.rx_slice + 4'd1;
				if (st.rx_slice == `SLICE_S1) begin
					next_st.votes[0] = rxd_in;
				end
				if (st.rx_slice == `SLICE_S2) begin
					next_st.votes[1] = rxd_in;
				end
				if (st.rx_slice == `SLICE_S3) begin
					bitv = (st.votes[0] & st.votes[1]) | (st.votes[0] & rxd_in)
						| (st.votes[1] & rxd_in);
					next_st.rx_bits = st.rx_bits + 4'd1;
					case (st.rx_st)
						serial_port_pkg::rx_start: begin
							if (bitv) begin
								next_st.rx_st = serial_port_pkg::rx_idle;
							end else begin
								next_st.rx_st = serial_port_pkg::rx_data;
							end
						end
						serial_port_pkg::rx_data: begin
							next_st.rx_shift = {bitv, st.rx_shift[8:1]};
							if (st.rx_bits == frame_bits - 4'd2) begin
								next_st.rx_st = serial_port_pkg::rx_stop;
							end
						end
						serial_port_pkg::rx_stop: begin
							next_st.rx_st = serial_port_pkg::rx_idle;
						end
						default: next_st.rx_st = serial_port_pkg::rx_idle;
					endcase
				end
			end
		end else begin
			next_st.rx_st = serial_port_pkg::rx_idle;
		end
		// load at stop-bit centre
		if (mode != 2'b00 && slice_tick && st.rx_slice == `SLICE_S3
			&& st.rx_st == serial_port_pkg::rx_stop) begin
			// ninth carrier: stop bit in mode 1, ninth bit in modes 2 and 3
			nine = mode[1] ? st.rx_shift[8] : bitv;
			if (!rx_flag && (!st.serial_control_reg[`CTL_MP_FILTER] || nine)) begin
				next_st.serial_control_reg[`CTL_RX_NINTH] = nine;
				next_st.serial_buffer = mode[1] ? st.rx_shift[7:0] : st.rx_shift[8:1];
				next_st.serial_control_reg[`CTL_RX_FLAG] = 1'b1;
				next_st.events[0] = 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st <= '0;
			st.serial_control_reg <= `RESET_CTL;
			st.txd <= 1'b1;
			st.rxd_out <= 1'b1;
			st.rx_prev <= 1'b1;
			st.tx_shift <= 10'h3FF;
		end else if (clk_en) begin
			st <= next_st;
		end
	end

	assign txd = st.txd;
	assign rxd_out = st.rxd_out;
	assign rxd_oe = st.rxd_oe;

endmodule

// ===== bench/serial_port_props.sv
// port-level assertions for the serial port
`timescale 1ns/10ps
`include "serial_port_defines.svh"

module serial_port_props (
	// clock and reset
	input wire logic        clk,
	input wire logic        sys_rst,
	input wire logic        clk_en,
	// apb
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// serial pins
	input wire logic        rxd_in,
	input wire logic        rxd_out,
	input wire logic        rxd_oe,
	input wire logic        txd,
	// interrupt
	input wire logic        irq
);
	logic [1:0] mode_q;
	logic [1:0] mask_q;
	logic [4:0] low_cnt;
	logic       wr_ok;

	// -------------------------------------------
	// mirrors of mode and mask, shift-clock low time
	// -------------------------------------------
	assign wr_ok = psel && penable && pready && pwrite && !pslverr;
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			mode_q  <= 2'h0;
			mask_q  <= 2'h0;
			low_cnt <= 5'h0;
		end else begin
			if (wr_ok && paddr == `OFS_CONTROL)
				mode_q <= pwdata[7:6];
			if (wr_ok && paddr == `OFS_IRQ_MASK)
				mask_q <= pwdata[1:0];
			low_cnt <= (!txd && mode_q == 2'h0) ? low_cnt + 5'h1 : 5'h0;
		end
	end

	// -------------------------------------------
	// properties
	// -------------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);

	a_rst_values: assert property (@(posedge clk) disable iff (1'b0)
		sys_rst |=> txd && !rxd_oe && !irq && !pready && prdata == 32'h0)
		else $error("outputs not at reset level");
	a_ready_wait: assert property (psel && penable && !pready && clk_en |=> pready)
		else $error("apb answer not after one wait state");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_err_unmapped: assert property (pready |->
		pslverr == (paddr > `OFS_IRQ_MASK || paddr[1:0] != 2'h0))
		else $error("pslverr wrong for address");
	a_err_zero: assert property (pready && pslverr |-> prdata == 32'h0)
		else $error("refused access returned data");
	a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h00_0000)
		else $error("upper read bits not zero");
	a_oe_mode0: assert property (rxd_oe |-> mode_q == 2'h0)
		else $error("data pin driven outside mode 0");
	a_shift_half: assert property ({1'b0, low_cnt} <= `DIV_MODE0_HALF)
		else $error("mode 0 shift clock low too long");
	a_irq_masked: assert property (irq |-> mask_q != 2'h0)
		else $error("interrupt with all sources masked");
	a_irq_status: assert property (pready && !pwrite && paddr == `OFS_IRQ_STAT
		&& (prdata[1:0] & mask_q) != 2'h0 |-> irq || $past(irq))
		else $error("unmasked status without interrupt");
endmodule

bind serial_port serial_port_props chk (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd_in(rxd_in),
	.rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd(txd), .irq(irq));

// ===== bench/remote_serial.sv
// model of the remote serial device on the data and clock pins
`timescale 1ns/10ps

module remote_serial (
	// serial pins seen from the far side
	input wire logic clk,
	input wire logic txd,
	input wire logic rxd_out,
	input wire logic rxd_oe,
	output logic     rxd_in
);
	logic drv;
	int   cyc;

	// the port drives the data pin in mode 0 transmit, we do otherwise
	assign rxd_in = rxd_oe ? rxd_out : drv;
	initial drv = 1'b1;
	always @(posedge clk) cyc <= cyc + 1;

	// send nb bits lsb first, per clocks each, then idle high
	task automatic send(input logic [10:0] bits, input int nb, input int per);
		for (int i = 0; i < nb; i++) begin
			drv <= bits[i];
			repeat (per) @(posedge clk);
		end
		drv <= 1'b1;
	endtask

	// capture a frame, sampling each bit at its middle
	task automatic get(input int nb, input int per, output logic [10:0] bits);
		bits = 11'h0;
		@(negedge txd);
		repeat (per / 2) @(posedge clk);
		for (int i = 0; i < nb; i++) begin
			bits[i] = txd;
			repeat (per) @(posedge clk);
		end
	endtask

	// mode 0: latch on shift-clock rises, report last bit period
	task automatic get0(output logic [7:0] d, output int per);
		int t;
		t = cyc;
		for (int i = 0; i < 8; i++) begin
			@(posedge txd);
			d[i] = rxd_out;
			per = cyc - t;
			t = cyc;
		end
	endtask

	// mode 0: present the next bit after each shift-clock fall
	task automatic put0(input logic [7:0] d);
		for (int i = 0; i < 8; i++) begin
			drv <= d[i];
			@(posedge txd);
			if (i < 7)
				@(negedge txd);
			@(posedge clk);
		end
		drv <= 1'b1;
	endtask
endmodule

// ===== bench/local_serial_port_modes_baud_tb.sv
// self-checking bench for the serial port
`timescale 1ns/10ps
`include "serial_port_defines.svh"

module local_serial_port_modes_baud_tb;
	logic        clk, sys_rst, clk_en, psel, penable, pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic        pready, pslverr, rxd_in, rxd_out, rxd_oe, txd, irq;
	int          mismatches, samples_checked, cycles;

	serial_port uut (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd_in(rxd_in),
		.rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd(txd), .irq(irq));
	remote_serial far (.clk(clk), .txd(txd), .rxd_out(rxd_out), .rxd_oe(rxd_oe),
		.rxd_in(rxd_in));

	// -------------------------------------------
	// clock, timeout, reporting
	// -------------------------------------------
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			mismatches++;
			print_verdict();
		end
	end
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask

	// -------------------------------------------
	// apb master
	// -------------------------------------------
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 32'h0, r, e);
		chk(r, exp);
	endtask

	// -------------------------------------------
	// scenarios
	// -------------------------------------------
	task automatic t_regs;
		logic [31:0] r;
		logic        e;
		rd(`OFS_CONTROL, 32'h0);
		rd(`OFS_POWER, 32'h0);
		rd(`OFS_RELOAD, 32'h0);
		rd(`OFS_IRQ_STAT, 32'h0);
		wr(`OFS_IRQ_MASK, 32'h3);
		rd(`OFS_IRQ_MASK, 32'h3);
		wr(`OFS_IRQ_MASK, 32'h0);
		apb(1'b0, 12'h018, 32'h0, r, e);
		chk(r, 32'h0);
		chk({31'h0, e}, 32'h1);
		$display("registers done");
	endtask

	// transmit one frame and judge format, bit time and flags
	task automatic t_tx(input logic [31:0] ctl, pwr, rel, d, input int nb, per);
		logic [10:0] got;
		logic [10:0] exp;
		exp = (nb == 10) ? {2'b01, d[7:0], 1'b0} : {1'b1, ctl[3], d[7:0], 1'b0};
		wr(`OFS_POWER, pwr);
		wr(`OFS_RELOAD, rel);
		wr(`OFS_CONTROL, ctl);
		fork
			wr(`OFS_BUFFER, d);
			far.get(nb, per, got);
		join
		chk({21'h0, got}, {21'h0, exp});
		repeat (per) @(posedge clk);
		rd(`OFS_CONTROL, ctl | 32'h2);
		rd(`OFS_IRQ_STAT, 32'h2);
		wr(`OFS_CONTROL, ctl);
		$display("transmit mode %0d done", ctl[7:6]);
	endtask

	task automatic t_mode0;
		logic [7:0] d;
		int         per;
		wr(`OFS_CONTROL, 32'h0);
		fork
			wr(`OFS_BUFFER, 32'h6b);
			far.get0(d, per);
		join
		chk({24'h0, d}, 32'h6b);
		chk(per, {26'h0, `DIV_MODE0});
		repeat (40) @(posedge clk);
		rd(`OFS_CONTROL, 32'h2);
		rd(`OFS_IRQ_STAT, 32'h2);
		fork
			far.put0(8'hc3);
			wr(`OFS_CONTROL, 32'h10);
		join
		repeat (40) @(posedge clk);
		rd(`OFS_CONTROL, 32'h11);
		rd(`OFS_BUFFER, 32'hc3);
		rd(`OFS_IRQ_STAT, 32'h1);
		wr(`OFS_CONTROL, 32'h0);
		$display("mode 0 done");
	endtask

	// mode 2 receive: load, overrun, filter, false start
	task automatic t_rx2;
		wr(`OFS_POWER, 32'h80);
		wr(`OFS_IRQ_MASK, 32'h1);
		wr(`OFS_CONTROL, 32'h90);
		far.send({2'b11, 8'ha5, 1'b0}, 11, 32);
		repeat (4) @(posedge clk);
		chk({31'h0, irq}, 32'h1);
		rd(`OFS_CONTROL, 32'h95);
		rd(`OFS_BUFFER, 32'ha5);
		rd(`OFS_IRQ_STAT, 32'h1);
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h0);
		far.send({2'b11, 8'h3c, 1'b0}, 11, 32);
		rd(`OFS_BUFFER, 32'ha5);
		wr(`OFS_CONTROL, 32'hb0);
		far.send({2'b10, 8'h11, 1'b0}, 11, 32);
		far.send({2'b11, 8'h44, 1'b0}, 11, 32);
		rd(`OFS_CONTROL, 32'hb5);
		rd(`OFS_BUFFER, 32'h44);
		wr(`OFS_CONTROL, 32'h90);
		far.send(11'h0, 1, 4);
		repeat (64) @(posedge clk);
		far.send({2'b10, 8'h22, 1'b0}, 11, 32);
		rd(`OFS_CONTROL, 32'h91);
		rd(`OFS_BUFFER, 32'h22);
		$display("mode 2 receive done");
	endtask

	// -------------------------------------------
	// main sequence
	// -------------------------------------------
	initial begin
		sys_rst = 1'b1;
		clk_en = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h0;
		pwdata = 32'h0;
		repeat (6) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		t_regs();
		t_tx(32'h80, 32'h0, 32'h0, 32'ha6, 11, 64);
		t_tx(32'h88, 32'h80, 32'h0, 32'h59, 11, 32);
		t_tx(32'hc8, 32'h80, 32'hff, 32'h3d, 11, 192);
		t_tx(32'h40, 32'h0, 32'hfe, 32'hc2, 10, 768);
		t_mode0();
		t_rx2();
		print_verdict();
	end
endmodule
